// ==== include/eald_defines.vh ====
// constants for the external area decoder and lane steering
// assumes a single bus clock; included by bare name from verilog/
`ifndef EALD_DEFINES_VH
`define EALD_DEFINES_VH

// ****************************************
// address decode
// ****************************************
`define EALD_AREA_MSB 28
`define EALD_AREA_LSB 26
`define EALD_AREA0 3'h0
`define EALD_AREA1 3'h1
`define EALD_AREA2 3'h2
`define EALD_AREA3 3'h3
`define EALD_AREA4 3'h4

// ****************************************
// widths and access sizes
// ****************************************
`define EALD_WID_8 2'h1
`define EALD_WID_16 2'h2
`define EALD_WID_32 2'h3
`define EALD_SIZE_BYTE 2'h0
`define EALD_SIZE_WORD 2'h1
`define EALD_SIZE_LONG 2'h2

// ****************************************
// sequencer states
// ****************************************
`define EALD_ST_IDLE 3'h0
`define EALD_ST_T1 3'h1
`define EALD_ST_TW 3'h2
`define EALD_ST_T2 3'h3
`define EALD_ST_SACT 3'h4
`define EALD_ST_SCMD 3'h5
`define EALD_ST_SCL 3'h6

// ****************************************
// timing counts
// ****************************************
`define EALD_BURST_PITCH_MIN 4'h2
`define EALD_BURST_PITCH_MAX 4'ha
`define EALD_BURST_UNITS_M1 2'h3
`define EALD_COL_BITS_BASE 5'h8

`endif

// ==== verilog/eald_lane_steer.v ====
// little-endian byte lane steering for one beat of an access
// assumes values are right-aligned on the request side
`timescale 1ns/1ps
`include "eald_defines.vh"

module eald_lane_steer (
  // beat description
  input wire [1:0] dev_width,
  input wire [1:0] size,
  input wire [1:0] addr_lo,
  input wire [1:0] beat,
  input wire [31:0] wdata,
  // steered beat
  output reg [31:0] bus_wdata,
  output reg [3:0] strobe,
  output reg [4:0] lane_shift,
  output reg [4:0] piece_shift,
  output reg [31:0] rd_mask,
  output reg [1:0] beats_m1
);

  reg [2:0] dev_bytes;
  reg [2:0] size_bytes;
  reg [2:0] piece_bytes;
  reg [31:0] piece;

  // ****************************************
  // steering
  // ****************************************
  always @*
  begin
    case (dev_width)
      `EALD_WID_8: dev_bytes = 3'h1;
      `EALD_WID_16: dev_bytes = 3'h2;
      default: dev_bytes = 3'h4;
    endcase
    case (size)
      `EALD_SIZE_BYTE: size_bytes = 3'h1;
      `EALD_SIZE_WORD: size_bytes = 3'h2;
      default: size_bytes = 3'h4;
    endcase
    // split into ascending beats, least significant first
    if (size_bytes > dev_bytes)
    begin
      piece_bytes = dev_bytes;
      beats_m1 = (size_bytes == 3'h4 && dev_bytes == 3'h1) ? 2'h3 :
        2'h1;
    end
    else
    begin
      piece_bytes = size_bytes;
      beats_m1 = 2'h0;
    end
    // 8-bit device always on lane 0, 16-bit picks by address bit 0
    case (dev_width)
      `EALD_WID_8: lane_shift = 5'h0;
      `EALD_WID_16: lane_shift = {1'b0, addr_lo[0], 3'h0};
      default: lane_shift = {addr_lo, 3'h0};
    endcase
    piece_shift = {beat, 3'h0} * {2'h0, dev_bytes};
    case (piece_bytes)
      3'h1: rd_mask = 32'h0000_00ff;
      3'h2: rd_mask = 32'h0000_ffff;
      default: rd_mask = 32'hffff_ffff;
    endcase
    case (piece_bytes)
      3'h1: strobe = 4'h1 << addr_lo_lane(lane_shift);
      3'h2: strobe = 4'h3 << addr_lo_lane(lane_shift);
      default: strobe = 4'hf;
    endcase
    piece = (wdata >> piece_shift) & rd_mask;
    // lanes without a strobe hold zero; memory must ignore them
    bus_wdata = piece << lane_shift;
  end

  function [1:0] addr_lo_lane;
    input [4:0] sh;
    begin
      addr_lo_lane = sh[4:3];
    end
  endfunction

endmodule // eald_lane_steer

// ==== verilog/eald_bridge.v ====
// external area decoder with wait control, bursts, sdram and lanes
// assumes a requester that holds req_* until req_ready, clean pins
`timescale 1ns/1ps
`include "eald_defines.vh"

module eald_bridge (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  // request side
  input wire req_valid,
  output wire req_ready,
  input wire [31:0] req_addr,
  input wire req_write,
  input wire [1:0] req_size,
  input wire req_burst,
  input wire [31:0] req_wdata,
  // answer side
  output reg rsp_valid_q,
  output reg rsp_error_q,
  output reg [31:0] rsp_rdata_q,
  // configuration
  input wire boot_width_pin_lo,
  input wire boot_width_pin_hi,
  input wire [2:0] area0_wait_count,
  input wire [1:0] area2_wait_count,
  input wire [1:0] area3_wait_count,
  input wire [2:0] area4_wait_count,
  input wire [1:0] area2_width_sel,
  input wire [1:0] area3_width_sel,
  input wire [1:0] area4_width_sel,
  input wire area2_is_sdram,
  input wire area3_is_sdram,
  input wire [1:0] sdram_col_sel,
  input wire [1:0] sdram_cas_latency,
  // external bus
  output reg [25:0] ext_addr_q,
  output reg [31:0] ext_wdata_q,
  output wire ext_wdata_oe,
  input wire [31:0] ext_rdata,
  input wire ext_wait_n,
  output wire area0_select_n,
  output wire area2_select_n,
  output wire area3_select_n,
  output wire area4_select_n,
  output wire read_strobe_n,
  output wire byte0_write_strobe_n,
  output wire byte1_write_strobe_n,
  output wire byte2_write_strobe_n,
  output wire byte3_write_strobe_n,
  // sdram
  output wire row_strobe_upper_n,
  output wire row_strobe_lower_n,
  output wire col_strobe_upper_n,
  output wire col_strobe_lower_n,
  output wire sdram_read_not_write,
  output wire lane0_mask_n,
  output wire sdram_lane1_mask_n,
  output wire sdram_lane2_mask_n,
  output wire sdram_lane3_mask_n
);

  // ****************************************
  // functions
  // ****************************************
  // 3-bit code to 0..10 waits
  function [3:0] wait_decode;
    input [2:0] code;
    begin
      case (code)
        3'h5: wait_decode = 4'h6;
        3'h6: wait_decode = 4'h8;
        3'h7: wait_decode = 4'ha;
        default: wait_decode = {1'b0, code};
      endcase
    end
  endfunction

  function [1:0] width_fix;
    input [1:0] sel;
    begin
      width_fix = (sel == 2'h0) ? `EALD_WID_32 : sel;
    end
  endfunction

  // ****************************************
  // reset release
  // ****************************************
  reg rst_meta_q;
  reg rst_sync_q;
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************
  // request decode
  // ****************************************
  reg [2:0] state_q;
  reg [31:0] addr_q;
  reg [31:0] wdata_q;
  reg [31:0] rdata_q;
  reg [2:0] area_q;
  reg [1:0] width_q;
  reg [1:0] size_q;
  reg [3:0] waits_q;
  reg [3:0] cnt_q;
  reg [1:0] beat_q;
  reg [1:0] unit_q;
  reg [1:0] beats_m1_q;
  reg [4:0] lane_q;
  reg [4:0] piece_q;
  reg [31:0] rmask_q;
  reg [3:0] strobe_q;
  reg write_q;
  reg burst_q;
  reg sdram_q;

  // bits 31..29 ignored, so every shadow copy decodes the same
  wire [2:0] req_area = req_addr[`EALD_AREA_MSB:`EALD_AREA_LSB];
  reg req_ext;
  reg req_sdram;
  reg [1:0] req_width;
  reg [3:0] req_waits;
  always @*
  begin
    req_ext = 1'b1;
    req_sdram = 1'b0;
    req_width = `EALD_WID_32;
    req_waits = 4'h0;
    case (req_area)
      `EALD_AREA0:
      begin
        req_width =
          width_fix({boot_width_pin_hi, boot_width_pin_lo});
        req_waits = wait_decode(area0_wait_count);
      end
      `EALD_AREA1: req_ext = 1'b0;
      `EALD_AREA2:
      begin
        req_sdram = area2_is_sdram;
        req_width = area2_is_sdram ? `EALD_WID_32 :
          width_fix(area2_width_sel);
        req_waits = {2'h0, area2_wait_count};
      end
      `EALD_AREA3:
      begin
        req_sdram = area3_is_sdram;
        req_width = area3_is_sdram ? `EALD_WID_32 :
          width_fix(area3_width_sel);
        req_waits = {2'h0, area3_wait_count};
      end
      `EALD_AREA4:
      begin
        req_width = width_fix(area4_width_sel);
        req_waits = wait_decode(area4_wait_count);
      end
      // areas above 4 are not served by this block
      default: req_ext = 1'b0;
    endcase
  end

  // bursts are 16-byte reads only; writes go one unit at a time
  wire req_bursting = req_burst & ~req_write & ~req_sdram;
  wire [1:0] req_eff_size = req_bursting ? `EALD_SIZE_LONG : req_size;
  wire idle = (state_q == `EALD_ST_IDLE);
  assign req_ready = idle & clk_en & rst_sync_q;
  wire take = req_ready & req_valid;

  // ****************************************
  // next beat steering
  // ****************************************
  wire beat_last = (beat_q == beats_m1_q);
  wire more_units = burst_q & (unit_q != `EALD_BURST_UNITS_M1);
  wire in_t2 = (state_q == `EALD_ST_T2);
  wire load_beat = (take & req_ext) |
    (in_t2 & (~beat_last | more_units));
  wire [1:0] ln_beat = (idle | beat_last) ? 2'h0 : beat_q + 2'h1;
  wire [31:0] base_next = idle ? req_addr :
    (beat_last ? addr_q + 32'h4 : addr_q);
  wire [1:0] ln_width = idle ? req_width : width_q;
  wire [31:0] ln_bus_wdata;
  wire [3:0] ln_strobe;
  wire [4:0] ln_lane;
  wire [4:0] ln_piece;
  wire [31:0] ln_rmask;
  wire [1:0] ln_beats_m1;

  eald_lane_steer u_steer (
    .dev_width(ln_width),
    .size(idle ? req_eff_size : size_q),
    .addr_lo(base_next[1:0]),
    .beat(ln_beat),
    .wdata(idle ? req_wdata : wdata_q),
    .bus_wdata(ln_bus_wdata),
    .strobe(ln_strobe),
    .lane_shift(ln_lane),
    .piece_shift(ln_piece),
    .rd_mask(ln_rmask),
    .beats_m1(ln_beats_m1)
  );

  // ascending byte addresses, one device width per beat
  wire [25:0] ln_step = (ln_width == `EALD_WID_8) ? {24'h0, ln_beat} :
    (ln_width == `EALD_WID_16) ? {23'h0, ln_beat, 1'b0} : 26'h0;
  wire [25:0] nxt_ext_addr = base_next[25:0] + ln_step;
  wire [4:0] col_bits = `EALD_COL_BITS_BASE + {3'h0, sdram_col_sel};
  wire [25:0] row_addr = req_addr[25:0] >> (col_bits + 5'h2);
  wire [25:0] col_addr = (addr_q[25:0] >> 2) &
    ~(26'h3ff_ffff << col_bits);
  wire [31:0] rd_piece = ((ext_rdata >> lane_q) & rmask_q) << piece_q;
  wire [31:0] rdata_full = rdata_q | rd_piece;
  // pitch = waits + 2, capped; TW count is pitch minus two
  wire [3:0] pitch_cnt = (waits_q > (`EALD_BURST_PITCH_MAX -
    `EALD_BURST_PITCH_MIN)) ? (`EALD_BURST_PITCH_MAX -
    `EALD_BURST_PITCH_MIN) : waits_q;

  // ****************************************
  // beat registers
  // ****************************************
  always @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      ext_addr_q <= 26'h0;
      ext_wdata_q <= 32'h0;
      lane_q <= 5'h0;
      piece_q <= 5'h0;
      rmask_q <= 32'h0;
      strobe_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (load_beat)
      begin
        ext_addr_q <= (idle & req_sdram) ? row_addr : nxt_ext_addr;
        ext_wdata_q <= ln_bus_wdata;
        lane_q <= ln_lane;
        piece_q <= ln_piece;
        rmask_q <= ln_rmask;
        strobe_q <= ln_strobe;
      end
      else if (state_q == `EALD_ST_SACT)
        ext_addr_q <= col_addr;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      state_q <= `EALD_ST_IDLE;
      addr_q <= 32'h0;
      wdata_q <= 32'h0;
      rdata_q <= 32'h0;
      area_q <= 3'h0;
      width_q <= `EALD_WID_32;
      size_q <= `EALD_SIZE_BYTE;
      waits_q <= 4'h0;
      cnt_q <= 4'h0;
      beat_q <= 2'h0;
      unit_q <= 2'h0;
      beats_m1_q <= 2'h0;
      write_q <= 1'b0;
      burst_q <= 1'b0;
      sdram_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_error_q <= 1'b0;
      rsp_rdata_q <= 32'h0;
    end
    else if (clk_en)
    begin
      rsp_valid_q <= 1'b0;
      rsp_error_q <= 1'b0;
      case (state_q)
        `EALD_ST_IDLE:
          if (take)
          begin
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            rdata_q <= 32'h0;
            area_q <= req_area;
            width_q <= req_width;
            size_q <= req_eff_size;
            waits_q <= req_waits;
            beat_q <= 2'h0;
            unit_q <= 2'h0;
            beats_m1_q <= ln_beats_m1;
            write_q <= req_write;
            burst_q <= req_bursting;
            sdram_q <= req_sdram;
            if (!req_ext)
            begin
              // answered at once, nothing reaches the pins
              rsp_valid_q <= 1'b1;
              rsp_error_q <= 1'b1;
            end
            else if (req_sdram)
              state_q <= `EALD_ST_SACT;
            else
              state_q <= `EALD_ST_T1;
          end
        `EALD_ST_T1:
        begin
          cnt_q <= (waits_q == 4'h0) ? 4'h0 : waits_q - 4'h1;
          if (waits_q == 4'h0 && ext_wait_n)
            state_q <= `EALD_ST_T2;
          else
            state_q <= `EALD_ST_TW;
        end
        `EALD_ST_TW:
          if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
          else if (ext_wait_n)
            state_q <= `EALD_ST_T2;
        `EALD_ST_T2:
        begin
          rdata_q <= write_q ? 32'h0 : rdata_full;
          if (!beat_last)
          begin
            beat_q <= beat_q + 2'h1;
            state_q <= `EALD_ST_T1;
          end
          else
          begin
            rsp_valid_q <= 1'b1;
            rsp_rdata_q <= write_q ? 32'h0 : rdata_full;
            if (more_units)
            begin
              // next longword skips T1, spaced by the burst pitch
              unit_q <= unit_q + 2'h1;
              addr_q <= addr_q + 32'h4;
              beat_q <= 2'h0;
              rdata_q <= 32'h0;
              cnt_q <= pitch_cnt;
              state_q <= `EALD_ST_TW;
            end
            else
              state_q <= `EALD_ST_IDLE;
          end
        end
        `EALD_ST_SACT:
          state_q <= `EALD_ST_SCMD;
        `EALD_ST_SCMD:
        begin
          cnt_q <= (sdram_cas_latency == 2'h0) ? 4'h0 :
            {2'h0, sdram_cas_latency} - 4'h1;
          if (write_q)
          begin
            rsp_valid_q <= 1'b1;
            state_q <= `EALD_ST_IDLE;
          end
          else
            state_q <= `EALD_ST_SCL;
        end
        `EALD_ST_SCL:
          if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
          else
          begin
            rsp_valid_q <= 1'b1;
            rsp_rdata_q <= rdata_full;
            state_q <= `EALD_ST_IDLE;
          end
        default: state_q <= `EALD_ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  wire basic = (state_q == `EALD_ST_T1) | (state_q == `EALD_ST_TW) | in_t2;
  // write strobes drop in T2 so data holds past their rising edge
  wire we_on = write_q & ((state_q == `EALD_ST_T1) |
    (state_q == `EALD_ST_TW));
  wire busy = ~idle;
  wire sd_cmd = (state_q == `EALD_ST_SCMD);
  wire sd_mask_on = sd_cmd | (state_q == `EALD_ST_SCL);

  assign area0_select_n = ~(busy & area_q == `EALD_AREA0);
  assign area2_select_n = ~(busy & area_q == `EALD_AREA2);
  assign area3_select_n = ~(busy & area_q == `EALD_AREA3);
  assign area4_select_n = ~(busy & area_q == `EALD_AREA4);
  assign read_strobe_n = ~(basic & ~write_q);
  assign byte0_write_strobe_n = ~(we_on & strobe_q[0]);
  assign byte1_write_strobe_n = ~(we_on & strobe_q[1]);
  assign byte2_write_strobe_n = ~(we_on & strobe_q[2]);
  assign byte3_write_strobe_n = ~(we_on & strobe_q[3]);
  assign ext_wdata_oe = write_q & (basic | sd_cmd);
  assign row_strobe_upper_n = ~(state_q == `EALD_ST_SACT);
  assign row_strobe_lower_n = ~(state_q == `EALD_ST_SACT);
  assign col_strobe_upper_n = ~sd_cmd;
  assign col_strobe_lower_n = ~sd_cmd;
  assign sdram_read_not_write = ~(sdram_q & write_q & busy);
  assign lane0_mask_n = ~(sd_mask_on & strobe_q[0]);
  assign sdram_lane1_mask_n = ~(sd_mask_on & strobe_q[1]);
  assign sdram_lane2_mask_n = ~(sd_mask_on & strobe_q[2]);
  assign sdram_lane3_mask_n = ~(sd_mask_on & strobe_q[3]);

endmodule // eald_bridge

// ==== verification/eald_bridge_asserts.sv ====
// checker for the area decoder bridge
// assumes it is bound to eald_bridge and sees only its ports
`timescale 1ns/1ps
module eald_bridge_asserts (
  // clock and request
  input wire ref_clk,
  input wire rst_n,
  input wire req_valid,
  input wire req_ready,
  input wire [31:0] req_addr,
  input wire req_write,
  input wire rsp_valid_q,
  input wire rsp_error_q,
  // configuration
  input wire boot_width_pin_lo,
  input wire boot_width_pin_hi,
  input wire [2:0] area0_wait_count,
  input wire [1:0] area2_wait_count,
  input wire [1:0] area3_wait_count,
  input wire [1:0] area2_width_sel,
  input wire [1:0] area3_width_sel,
  input wire area2_is_sdram,
  input wire area3_is_sdram,
  // pins
  input wire ext_wait_n,
  input wire ext_wdata_oe,
  input wire area0_select_n,
  input wire area2_select_n,
  input wire area3_select_n,
  input wire area4_select_n,
  input wire read_strobe_n,
  input wire byte0_write_strobe_n,
  input wire byte1_write_strobe_n,
  input wire byte2_write_strobe_n,
  input wire byte3_write_strobe_n,
  input wire row_strobe_upper_n,
  input wire col_strobe_upper_n
);
  wire take = req_valid && req_ready;
  wire [2:0] area = req_addr[28:26];
  wire w0 = boot_width_pin_hi == boot_width_pin_lo;
  wire quiet = &{area0_select_n, area2_select_n, area3_select_n,
    area4_select_n, read_strobe_n, byte0_write_strobe_n,
    byte1_write_strobe_n, byte2_write_strobe_n, byte3_write_strobe_n};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_area0_decode: assert property (take && area == 3'h0 |=>
    !area0_select_n && area2_select_n && area3_select_n &&
    read_strobe_n == $past(req_write)) else $error("area 0 decode wrong");
  a_area1_quiet: assert property (take && area == 3'h1 |=>
    rsp_valid_q && rsp_error_q && quiet) else $error("area 1 moved pins");
  a_area2_decode: assert property (take && area == 3'h2 |=>
    !area2_select_n && area0_select_n) else $error("area 2 decode wrong");
  a_area3_decode: assert property (take && area == 3'h3 |=>
    !area3_select_n && area4_select_n) else $error("area 3 decode wrong");
  a_area4_decode: assert property (take && area == 3'h4 |=>
    !area4_select_n && area0_select_n && read_strobe_n == $past(req_write))
    else $error("area 4 decode wrong");
  a_sdram_row_col: assert property (take && area == 3'h2 &&
    area2_is_sdram |=> !row_strobe_upper_n && read_strobe_n ##1
    !col_strobe_upper_n && row_strobe_upper_n) else $error("sdram order");
  a_a0_zero_wait: assert property ($fell(area0_select_n) && w0 &&
    area0_wait_count == 3'h0 && ext_wait_n |=> !area0_select_n ##1
    area0_select_n) else $error("area 0 zero wait length");
  a_a0_six_wait: assert property (($fell(area0_select_n) && w0 &&
    area0_wait_count == 3'h5) ##6 ext_wait_n |-> ##1 !area0_select_n ##1
    area0_select_n) else $error("area 0 code 5 length");
  a_a2_three_wait: assert property (($fell(area2_select_n) &&
    !area2_is_sdram && area2_width_sel[1] == area2_width_sel[0] &&
    area2_wait_count == 2'h3) ##3 ext_wait_n |-> ##1 !area2_select_n ##1
    area2_select_n) else $error("area 2 wait length");
  a_a3_one_wait: assert property (($fell(area3_select_n) &&
    !area3_is_sdram && area3_width_sel[1] == area3_width_sel[0] &&
    area3_wait_count == 2'h1) ##1 ext_wait_n |-> ##1 !area3_select_n ##1
    area3_select_n) else $error("area 3 wait length");
  a_wait_stretch: assert property (
    (!area0_select_n && !ext_wait_n) [*2] |=> !area0_select_n)
    else $error("external wait ignored");
  a_byte_lane8: assert property (!area0_select_n &&
    {boot_width_pin_hi, boot_width_pin_lo} == 2'h1 |-> byte1_write_strobe_n
    && byte2_write_strobe_n && byte3_write_strobe_n)
    else $error("8-bit lane strobe");
  a_oe_write: assert property (!(&{byte0_write_strobe_n,
    byte1_write_strobe_n, byte2_write_strobe_n, byte3_write_strobe_n}) |->
    ext_wdata_oe) else $error("write strobe without data drive");
  a_rsp_pitch: assert property (rsp_valid_q |=> !rsp_valid_q)
    else $error("answer pitch below 2");
endmodule // eald_bridge_asserts

bind eald_bridge eald_bridge_asserts u_chk (.*);

// ==== verification/eald_mem_model.sv ====
// behavioural memory on the far side of the bridge pins
// assumes one device width for all areas, set by the bench
`timescale 1ns/1ps
module eald_mem_model (
  // bus pins
  input wire ref_clk,
  input wire [25:0] ext_addr_q,
  input wire [31:0] ext_wdata_q,
  input wire [3:0] sel_n,
  input wire [3:0] we_n,
  // bench knobs
  input wire [1:0] dev_width,
  input wire [3:0] stall,
  // answers
  output reg [31:0] ext_rdata,
  output wire ext_wait_n
);
  reg [7:0] mem [0:255];
  reg [31:0] last_q = 32'h0;
  reg [3:0] cnt_q = 4'h0;
  integer i;
  integer k;
  wire sel = ~&sel_n;
  wire [7:0] nb = (dev_width == 2'h1) ? 8'h1 :
    (dev_width == 2'h2) ? 8'h2 : 8'h4;
  wire [7:0] base = ext_addr_q[7:0] & ~(nb - 8'h1);
  // low for the first stall cycles of each access
  assign ext_wait_n = !(sel && cnt_q < stall);
  initial
    for (i = 0; i < 256; i = i + 1)
      mem[i] = i[7:0] ^ 8'h5a;
  // idle lanes toggle so a stale value never passes for data
  always_comb
  begin
    ext_rdata = ~last_q;
    for (int j = 0; j < 4; j = j + 1)
      if (sel && j < nb)
        ext_rdata[8*j +: 8] = mem[base + j];
  end
  always @(posedge ref_clk)
  begin
    cnt_q <= sel ? cnt_q + (cnt_q != 4'hf) : 4'h0;
    if (sel)
      last_q <= ext_rdata;
    for (k = 0; k < 4; k = k + 1)
      if (!we_n[k] && k < nb)
        mem[base + k] <= ext_wdata_q[8*k +: 8];
  end
endmodule // eald_mem_model

// ==== verification/eald_bridge_tb.sv ====
// self-checking bench for the area decoder bridge
// assumes eald_bridge, the memory model and the bound checker
`timescale 1ns/1ps
module eald_bridge_tb;
  reg ref_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, req_valid = 1'h0;
  reg req_write = 1'h0, req_burst = 1'h0, area2_is_sdram = 1'h0;
  reg area3_is_sdram = 1'h0, boot_width_pin_lo = 1'h1;
  reg boot_width_pin_hi = 1'h1;
  reg [31:0] req_addr = 32'h0, req_wdata = 32'h0;
  reg [1:0] req_size = 2'h0, area2_wait_count = 2'h0, dev_width = 2'h3;
  reg [1:0] area3_wait_count = 2'h0, area2_width_sel = 2'h3;
  reg [1:0] area3_width_sel = 2'h3, area4_width_sel = 2'h3;
  reg [1:0] sdram_col_sel = 2'h0, sdram_cas_latency = 2'h2;
  reg [2:0] area0_wait_count = 3'h0, area4_wait_count = 3'h0;
  reg [3:0] stall = 4'h0;
  reg [31:0] rd;
  reg err;
  wire req_ready, rsp_valid_q, rsp_error_q, ext_wdata_oe, ext_wait_n;
  wire area0_select_n, area2_select_n, area3_select_n, area4_select_n;
  wire read_strobe_n, byte0_write_strobe_n, byte1_write_strobe_n;
  wire byte2_write_strobe_n, byte3_write_strobe_n, row_strobe_upper_n;
  wire row_strobe_lower_n, col_strobe_upper_n, col_strobe_lower_n;
  wire sdram_read_not_write, lane0_mask_n, sdram_lane1_mask_n;
  wire sdram_lane2_mask_n, sdram_lane3_mask_n;
  wire [31:0] rsp_rdata_q, ext_wdata_q, ext_rdata;
  wire [25:0] ext_addr_q;
  integer n_errors = 0, samples_checked = 0, lat, pitch, base_lat, i, a;
  always #4 ref_clk = ~ref_clk;
  eald_bridge dut (.*);
  eald_mem_model u_mem (.ref_clk(ref_clk), .ext_addr_q(ext_addr_q),
    .ext_wdata_q(ext_wdata_q), .dev_width(dev_width), .stall(stall),
    .sel_n({area4_select_n, area3_select_n, area2_select_n, area0_select_n}),
    .we_n({byte3_write_strobe_n, byte2_write_strobe_n, byte1_write_strobe_n,
      byte0_write_strobe_n}), .ext_rdata(ext_rdata), .ext_wait_n(ext_wait_n));
  // ****
  // helpers
  // ****
  function [31:0] fw(input [7:0] b);
    fw = {b + 8'h3, b + 8'h2, b + 8'h1, b} ^ 32'h5a5a_5a5a;
  endfunction
  task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("Error %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task finish_test;
    begin
      if (n_errors == 0 && samples_checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // counts edges to the next answer; bounded so a hang shows as latency
  task wait_rsp(output integer n);
    begin
      n = 1;
      @(posedge ref_clk);
      while (rsp_valid_q !== 1'h1 && n < 400)
      begin
        @(posedge ref_clk);
        n = n + 1;
      end
    end
  endtask
  task access(input [31:0] ad, input w, input [1:0] sz, input [31:0] d,
    input b);
    begin
      req_valid <= 1'h1;
      req_addr <= ad;
      req_write <= w;
      req_size <= sz;
      req_wdata <= d;
      req_burst <= b;
      @(posedge ref_clk);
      while (req_ready !== 1'h1)
        @(posedge ref_clk);
      req_valid <= 1'h0;
      wait_rsp(lat);
      err = rsp_error_q;
      if (b && !w)
        repeat (3) wait_rsp(pitch);
      rd = rsp_rdata_q;
    end
  endtask
  // ****
  // scenarios
  // ****
  task t_areas;
    for (i = 0; i < 8; i = i + 1)
    begin
      // plain single reads only: area 1 is never filled
      access({i[2:0] + 3'h1, i[2:0], 26'h10}, 1'h0, 2'h2, 32'h0,
        1'h0);
      chk("areaerr", i == 1 || i > 4, err);
      if (i != 1 && i < 5)
        chk("arearead", fw(8'h10), rd);
    end
  endtask
  task t_width;
    for (i = 3; i > 0; i = i - 1)
    begin
      {boot_width_pin_hi, boot_width_pin_lo} <= i[1:0];
      dev_width <= i[1:0];
      a = 32'h20 + 4 * i;
      access(a, 1'h1, 2'h2, 32'h1234_5670 + i, 1'h0);
      chk("memword", 32'h1234_5670 + i, {u_mem.mem[a + 3], u_mem.mem[a + 2],
        u_mem.mem[a + 1], u_mem.mem[a]});
      access(a, 1'h0, 2'h2, 32'h0, 1'h0);
      if (i == 3)
        base_lat = lat;
      chk("readback", 32'h1234_5670 + i, rd);
      chk("beats", base_lat + 2 * ((i == 1) ? 3 : 3 - i), lat);
      access(a + 1, 1'h0, 2'h0, 32'h0, 1'h0);
      chk("oddbyte", 32'h56, rd);
    end
  endtask
  task t_lanes;
    begin
      {boot_width_pin_hi, boot_width_pin_lo} <= 2'h2;
      dev_width <= 2'h2;
      access(32'h31, 1'h1, 2'h0, 32'ha5, 1'h0);
      chk("lane16", 16'ha56a,
        {u_mem.mem[49], u_mem.mem[48]});
      {boot_width_pin_hi, boot_width_pin_lo} <= 2'h3;
      dev_width <= 2'h3;
      access(32'h42, 1'h1, 2'h1, 32'hbeef, 1'h0);
      chk("lane32", 32'hbeef1b1a, {u_mem.mem[67], u_mem.mem[66],
        u_mem.mem[65], u_mem.mem[64]});
    end
  endtask
  task t_waits;
    for (i = 0; i < 8; i = i + 1)
    begin
      area0_wait_count <= i[2:0];
      area2_wait_count <= i[1:0];
      area3_wait_count <= i[1:0];
      access(32'h40, 1'h0, 2'h2, 32'h0, 1'h0);
      if (i == 0)
        base_lat = lat;
      chk("a0wait", base_lat + ((i < 5) ? i : 2 * i - 4), lat);
      if (i < 4)
      begin
        access(32'h0800_0040, 1'h0, 2'h2, 32'h0, 1'h0);
        chk("a2wait", base_lat + i, lat);
        access(32'h0c00_0040, 1'h0, 2'h2, 32'h0, 1'h0);
        chk("a3wait", base_lat + i, lat);
      end
    end
  endtask
  task t_ext_wait;
    begin
      area0_wait_count <= 3'h0;
      stall <= 4'h5;
      access(32'h44, 1'h0, 2'h2, 32'h0, 1'h0);
      chk("extwait", base_lat + 5, lat);
      stall <= 4'h0;
    end
  endtask
  task t_burst;
    for (i = 2; i < 8; i = i + 5)
    begin
      area0_wait_count <= i[2:0];
      access(32'h2000_0050, 1'h0, 2'h2, 32'h0, 1'h1);
      chk("pitch", (i == 2) ? 4 : 10, pitch);
      chk("burstdat", fw(8'h5c), rd);
    end
  endtask
  task t_sdram;
    begin
      area2_is_sdram <= 1'h1;
      area3_is_sdram <= 1'h1;
      access(32'h0800_0060, 1'h1, 2'h2, 32'h0, 1'h0);
      base_lat = lat;
      chk("sdramerr", 1'h0, err);
      for (i = 0; i < 4; i = i + 1)
      begin
        sdram_cas_latency <= i[1:0];
        access(32'h0c00_0060, 1'h0, 2'h2, 32'h0, 1'h0);
        chk("sdramlat", base_lat + ((i < 2) ? 1 : i), lat);
      end
    end
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
    t_areas;
    t_width;
    t_lanes;
    t_waits;
    t_ext_wait;
    t_burst;
    t_sdram;
    finish_test;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors = n_errors + 1;
    finish_test;
  end
endmodule // eald_bridge_tb
